// ---- pkg/dpr_defines.svh ----
// Register offsets, field positions and reset values of the profile pin router.
// Assumes byte addressing on a 32-bit Avalon-MM slave, one register per word.
`ifndef DPR_DEFINES_SVH
`define DPR_DEFINES_SVH

`define DPR_FUNC_OFS 8'h00
`define DPR_CH0_CFG_OFS 8'h04
`define DPR_CH1_CFG_OFS 8'h08
`define DPR_CH0_END_OFS 8'h0C
`define DPR_CH1_END_OFS 8'h10
`define DPR_STATUS_OFS 8'h14

`define DPR_LVL_LSB 8
`define DPR_RSEL_LSB 10
`define DPR_PCFG_LSB 12
`define DPR_SWEN_BIT 14
`define DPR_STYPE_LSB 22

`define DPR_FUNC_RST 32'h0000_0000
`define DPR_CFG_RST 32'h0000_0000
`define DPR_END_RST 32'h0000_0000

`define DPR_PCFG_PAIRS 3'h5
`define DPR_START_FREQ_REG 8'h04
`define DPR_START_PHASE_REG 8'h05
`define DPR_START_AMP_REG 8'h06
`define DPR_END_REG 8'h0A
`define DPR_SYNC_STAGES 2

`endif

// ---- pkg/dpr_pkg.sv ----
// Types shared by the profile pin router and its bench.
// Assumes the field positions given in dpr_defines.svh.
package dpr_pkg;

  typedef enum logic [1:0] {
    DPR_LVL_2,
    DPR_LVL_4,
    DPR_LVL_8,
    DPR_LVL_16
  } dpr_level_t;

  typedef enum logic [1:0] {
    DPR_RS_OFF,
    DPR_RS_PROF23,
    DPR_RS_PROF3,
    DPR_RS_SERIAL
  } dpr_ramp_sel_t;

  typedef enum logic [1:0] {
    DPR_SW_NONE,
    DPR_SW_AMP,
    DPR_SW_FREQ,
    DPR_SW_PHASE
  } dpr_sweep_type_t;

  typedef struct packed {
    logic [3:0] word_idx;
    logic ramp_en;
    logic ramp_down;
    logic sweep_active;
    logic sweep_up;
    logic sweep_rise;
    logic sweep_fall;
    logic [7:0] start_reg;
    logic [7:0] end_reg;
    logic [31:0] end_word;
  } dpr_chan_out_t;

endpackage : dpr_pkg

// ---- verilog/dpr_sync.sv ----
// Two-stage synchronizer for a bus of independent level inputs.
// Assumes each bit is a slow level; multi-bit values may skew by one cycle.
`timescale 1ns/1ps
module dpr_sync #(
  parameter int WIDTH = 7
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : dpr_sync

// ---- verilog/dpr_router.sv ----
// Profile pin and serial-data pin router for a two-channel synthesizer core.
// Assumes host pins are asynchronous and registers are reached over Avalon-MM.
//
// Function
// - No ramping, 16 levels: all profile pins go to channel chosen by pin_cfg.
// - Two-level, profile ramping, pin_cfg 101: pins 0/1 select, pins 2/3 ramp.
// - Eight-level, profile ramping: pins 0-2 select, pin 3 ramps same channel.
// - ramp_pin_sel 11 uses serial-data pins for ramps; levels 2, 4, 16 only.
// - Serial-data ramp pins force single-bit serial port; host avoids multi-bit.
// - Two-level with serial ramping: pin 2 selects channel 0, pin 3 channel 1.
// - Serial pins: first triggers, second picks channel, third picks direction.
// - Four-level serial ramping: pin pairs select, serial pins 1/2 ramp channels.
// - Four-level word index is pin pair value, lower pin as MSB.
// - 16-level serial ramping: pins 0-3 select, first serial pin ramps channel.
// - Sweep start from type's word-zero register, end from word one 0x0A.
// - End word keeps 32/14/10 bits, MSB aligned, low bits ignored.
// - In sweep, profile pin 2 drives channel 0 and pin 3 channel 1.
// - Sweep type 01 amplitude, 10 frequency, 11 phase, 00 none.
// - Output amplitude ramp usable around sweeps via otherwise unused pins.
// - Profile ramp pin low ramps up, high ramps down.
// - Rising pin edge starts rising sweep; falling edge starts falling sweep.
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "dpr_defines.svh"
module dpr_router (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [3:0] i_profile_pin,
  input wire logic [2:0] i_sdio_pin,
  output dpr_pkg::dpr_chan_out_t o_chan0,
  output dpr_pkg::dpr_chan_out_t o_chan1,
  output logic o_sdio_single_bit,
  output logic o_cfg_error
);

  logic [31:0] func_q;
  logic [31:0] cfg_q [2];
  logic [31:0] end_q [2];
  logic ack_q;
  logic [31:0] rdata_q;
  logic [6:0] pins_sync;
  logic [3:0] prof;
  logic [2:0] sdio;
  logic [1:0] sweep_pin_q;
  dpr_pkg::dpr_chan_out_t chan_q [2];
  logic single_bit_q;
  logic cfg_err_q;
  logic [3:0] idx_d [2];
  logic ramp_en_d [2];
  logic ramp_dn_d [2];
  logic [31:0] status;
  logic req;
  logic [2:0] pin_cfg;
  logic sel;
  dpr_pkg::dpr_level_t level;
  dpr_pkg::dpr_ramp_sel_t ramp_pin_sel;

  dpr_sync #(
    .WIDTH(7)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_sdio_pin, i_profile_pin}),
    .o_sync(pins_sync)
  );

  assign prof = pins_sync[3:0];
  assign sdio = pins_sync[6:4];
  assign pin_cfg = func_q[`DPR_PCFG_LSB +: 3];
  assign sel = pin_cfg[0];
  assign level = dpr_pkg::dpr_level_t'(func_q[`DPR_LVL_LSB +: 2]);
  assign ramp_pin_sel = dpr_pkg::dpr_ramp_sel_t'(func_q[`DPR_RSEL_LSB +: 2]);

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_be

  // One wait cycle per access keeps read data registered
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Writes land on the edge that completes the access
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      func_q <= `DPR_FUNC_RST;
    end else if (i_avs_write && ack_q && i_avs_address == `DPR_FUNC_OFS) begin
      func_q <= merge_be(func_q, i_avs_writedata, i_avs_byteenable);
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_cfg
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        cfg_q[c] <= `DPR_CFG_RST;
        end_q[c] <= `DPR_END_RST;
      end else if (i_avs_write && ack_q) begin
        if (i_avs_address == (`DPR_CH0_CFG_OFS + 8'(c * 4))) begin
          cfg_q[c] <= merge_be(cfg_q[c], i_avs_writedata, i_avs_byteenable);
        end
        if (i_avs_address == (`DPR_CH0_END_OFS + 8'(c * 4))) begin
          end_q[c] <= merge_be(end_q[c], i_avs_writedata, i_avs_byteenable);
        end
      end
    end
  end

  assign status = {12'h000, chan_q[1].word_idx, chan_q[0].word_idx, chan_q[1].ramp_down, chan_q[1].ramp_en,
                   chan_q[0].ramp_down, chan_q[0].ramp_en, cfg_err_q, pins_sync};

  // Unmapped reads answer zero, unmapped writes are dropped
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_avs_read && !ack_q) begin
      unique case (i_avs_address)
        `DPR_FUNC_OFS: rdata_q <= func_q;
        `DPR_CH0_CFG_OFS: rdata_q <= cfg_q[0];
        `DPR_CH1_CFG_OFS: rdata_q <= cfg_q[1];
        `DPR_CH0_END_OFS: rdata_q <= end_q[0];
        `DPR_CH1_END_OFS: rdata_q <= end_q[1];
        `DPR_STATUS_OFS: rdata_q <= status;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign o_avs_readdata = rdata_q;

  // Pin decode per modulation level and ramp pin setting
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      idx_d[c] = 4'h0;
      ramp_en_d[c] = 1'b0;
      ramp_dn_d[c] = 1'b0;
    end
    unique case (ramp_pin_sel)
      dpr_pkg::DPR_RS_OFF: begin
        unique case (level)
          dpr_pkg::DPR_LVL_2: begin
            idx_d[0] = {3'h0, prof[2]};
            idx_d[1] = {3'h0, prof[3]};
          end
          dpr_pkg::DPR_LVL_4: begin
            if (pin_cfg == `DPR_PCFG_PAIRS) begin
              idx_d[0] = {2'h0, prof[0], prof[1]};
              idx_d[1] = {2'h0, prof[2], prof[3]};
            end
          end
          dpr_pkg::DPR_LVL_8: begin
            if (pin_cfg[1]) begin
              idx_d[sel] = {1'b0, prof[0], prof[1], prof[2]};
            end
          end
          dpr_pkg::DPR_LVL_16: begin
            if (pin_cfg[1]) begin
              idx_d[sel] = {prof[0], prof[1], prof[2], prof[3]};
            end
          end
        endcase
      end
      dpr_pkg::DPR_RS_PROF23: begin
        if (pin_cfg == `DPR_PCFG_PAIRS && level == dpr_pkg::DPR_LVL_2) begin
          idx_d[0] = {3'h0, prof[0]};
          idx_d[1] = {3'h0, prof[1]};
          ramp_en_d[0] = 1'b1;
          ramp_en_d[1] = 1'b1;
          ramp_dn_d[0] = prof[2];
          ramp_dn_d[1] = prof[3];
        end
      end
      dpr_pkg::DPR_RS_PROF3: begin
        if (pin_cfg[1] && level == dpr_pkg::DPR_LVL_8) begin
          idx_d[sel] = {1'b0, prof[0], prof[1], prof[2]};
          ramp_en_d[sel] = 1'b1;
          ramp_dn_d[sel] = prof[3];
        end
      end
      dpr_pkg::DPR_RS_SERIAL: begin
        unique case (level)
          dpr_pkg::DPR_LVL_2: begin
            idx_d[0] = {3'h0, prof[2]};
            idx_d[1] = {3'h0, prof[3]};
            if (sdio[0]) begin
              ramp_en_d[sdio[1]] = 1'b1;
              ramp_dn_d[sdio[1]] = sdio[2];
            end
          end
          dpr_pkg::DPR_LVL_4: begin
            if (pin_cfg == `DPR_PCFG_PAIRS) begin
              idx_d[0] = {2'h0, prof[0], prof[1]};
              idx_d[1] = {2'h0, prof[2], prof[3]};
              ramp_en_d[0] = 1'b1;
              ramp_en_d[1] = 1'b1;
              ramp_dn_d[0] = sdio[0];
              ramp_dn_d[1] = sdio[1];
            end
          end
          dpr_pkg::DPR_LVL_8: begin
            // Unsupported combination: nothing routed
            idx_d[0] = 4'h0;
          end
          dpr_pkg::DPR_LVL_16: begin
            // four-bit index, serial pin 1 ramps
            if (pin_cfg[1]) begin
              idx_d[sel] = {prof[0], prof[1], prof[2], prof[3]};
              ramp_en_d[sel] = 1'b1;
              ramp_dn_d[sel] = sdio[0];
            end
          end
        endcase
      end
    endcase
  end

  // edge detect on synced sweep pins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sweep_pin_q <= 2'h0;
    end else begin
      sweep_pin_q <= prof[3:2];
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic sw_en;
    logic sw_pin;
    dpr_pkg::dpr_sweep_type_t sw_type;
    assign sw_type = dpr_pkg::dpr_sweep_type_t'(cfg_q[c][`DPR_STYPE_LSB +: 2]);
    assign sw_en = cfg_q[c][`DPR_SWEN_BIT] && sw_type != dpr_pkg::DPR_SW_NONE;
    // pin 2 for channel 0, pin 3 for channel 1
    assign sw_pin = prof[2 + c];

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        chan_q[c] <= '0;
      end else begin
        // Sweep owns the word select, so modulation index parks at zero
        chan_q[c].word_idx <= sw_en ? 4'h0 : idx_d[c];
        // ramp decode stays live during sweeps
        chan_q[c].ramp_en <= ramp_en_d[c];
        chan_q[c].ramp_down <= ramp_dn_d[c];
        chan_q[c].sweep_active <= sw_en;
        chan_q[c].sweep_up <= sw_en & sw_pin;
        chan_q[c].sweep_rise <= sw_en & sw_pin & ~sweep_pin_q[c];
        chan_q[c].sweep_fall <= sw_en & ~sw_pin & sweep_pin_q[c];
        unique case (sw_type)
          dpr_pkg::DPR_SW_AMP: chan_q[c].start_reg <= `DPR_START_AMP_REG;
          dpr_pkg::DPR_SW_PHASE: chan_q[c].start_reg <= `DPR_START_PHASE_REG;
          dpr_pkg::DPR_SW_FREQ: chan_q[c].start_reg <= `DPR_START_FREQ_REG;
          dpr_pkg::DPR_SW_NONE: chan_q[c].start_reg <= 8'h00;
        endcase
        chan_q[c].end_reg <= `DPR_END_REG;
        // MSB aligned end word, low bits dropped
        unique case (sw_type)
          dpr_pkg::DPR_SW_AMP: chan_q[c].end_word <= {22'h000000, end_q[c][31:22]};
          dpr_pkg::DPR_SW_PHASE: chan_q[c].end_word <= {18'h00000, end_q[c][31:18]};
          dpr_pkg::DPR_SW_FREQ: chan_q[c].end_word <= end_q[c];
          dpr_pkg::DPR_SW_NONE: chan_q[c].end_word <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_chan0 = chan_q[0];
  assign o_chan1 = chan_q[1];

  // serial ramp pins lock serial port to one bit
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      single_bit_q <= 1'b0;
    end else begin
      single_bit_q <= ramp_pin_sel == dpr_pkg::DPR_RS_SERIAL;
    end
  end

  // host misuse and unsupported combinations are flagged, not blocked
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg_err_q <= 1'b0;
    end else begin
      cfg_err_q <= (cfg_q[0][`DPR_SWEN_BIT] && level != dpr_pkg::DPR_LVL_2) ||
                   (cfg_q[1][`DPR_SWEN_BIT] && level != dpr_pkg::DPR_LVL_2) ||
                   (ramp_pin_sel == dpr_pkg::DPR_RS_SERIAL && level == dpr_pkg::DPR_LVL_8);
    end
  end

  assign o_sdio_single_bit = single_bit_q;
  assign o_cfg_error = cfg_err_q;

endmodule : dpr_router

// ---- test/dpr_host_model.sv ----
// Host side model: drives the profile and serial-data pins as plain levels.
// Assumes the bench hands it levels; they are launched one edge later.
`timescale 1ns/1ps
module dpr_host_model (
  input wire logic i_clk,
  input wire logic [3:0] i_prof,
  input wire logic [2:0] i_sdio,
  output logic [3:0] o_profile_pin,
  output logic [2:0] o_sdio_pin
);
  initial begin
    o_profile_pin = 4'h0;
    o_sdio_pin = 3'h0;
  end
  always @(posedge i_clk) begin
    o_profile_pin <= i_prof;
    o_sdio_pin <= i_sdio;
  end
endmodule : dpr_host_model

// ---- test/dpr_router_chk.sv ----
// Port checker for dpr_router, bound below.
// Assumes 3 edges from pin to output and one wait cycle per access.
`timescale 1ns/1ps
module dpr_router_chk (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [3:0] i_profile_pin,
  input wire dpr_pkg::dpr_chan_out_t o_chan0,
  input wire dpr_pkg::dpr_chan_out_t o_chan1
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_wait_first: assert property (
    $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest) else $error("no wait cycle");
  a_wait_one: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("long wait");
  a_end_reg: assert property (
    o_chan0.sweep_active |-> o_chan0.end_reg == 8'h0A && o_chan0.start_reg inside {8'h04, 8'h05, 8'h06})
    else $error("bad sweep registers");
  a_amp_width: assert property (
    o_chan0.sweep_active && o_chan0.start_reg == 8'h06 |-> o_chan0.end_word[31:10] == 22'h0)
    else $error("amplitude end word too wide");
  a_sweep_rise: assert property (
    o_chan0.sweep_rise |-> $past(i_profile_pin[2], 3) && !$past(i_profile_pin[2], 4)) else $error("bad rise");
  a_sweep_fall: assert property (
    o_chan0.sweep_fall |-> !$past(i_profile_pin[2], 3) && $past(i_profile_pin[2], 4)) else $error("bad fall");
  a_sweep_dir: assert property (
    o_chan1.sweep_active && $past(o_chan1.sweep_active) |-> o_chan1.sweep_up == $past(i_profile_pin[3], 3))
    else $error("channel 1 direction wrong");
  a_sweep_idx: assert property (
    o_chan0.sweep_active |-> o_chan0.word_idx == 4'h0) else $error("index set in sweep");
endmodule : dpr_router_chk

bind dpr_router dpr_router_chk u_dpr_router_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .i_profile_pin(i_profile_pin), .o_chan0(o_chan0), .o_chan1(o_chan1));

// ---- test/dpr_router_tb_top.sv ----
// Self-checking bench for the profile pin router.
// Assumes the host model, the bound checker and a 125 MHz clock.
`timescale 1ns/1ps
module dpr_router_tb_top;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hF;
  logic [3:0] pp = 4'h0;
  logic [2:0] sp = 3'h0;
  logic [3:0] prof;
  logic [2:0] sdio;
  logic [31:0] rdata;
  logic wreq;
  logic sbit;
  logic cerr;
  dpr_pkg::dpr_chan_out_t c0;
  dpr_pkg::dpr_chan_out_t c1;
  logic [31:0] seed = 32'h0000_1C15;
  logic [31:0] q;
  logic [31:0] e;
  logic [11:0] m;
  logic [1:0] lv;
  logic [1:0] rs;
  logic [2:0] pc;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  dpr_host_model u_dpr_host_model (.i_clk(i_clk), .i_prof(pp), .i_sdio(sp), .o_profile_pin(prof),
    .o_sdio_pin(sdio));
  dpr_router u_dpr_router (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(ad), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_profile_pin(prof), .i_sdio_pin(sdio), .o_chan0(c0), .o_chan1(c1),
    .o_sdio_single_bit(sbit), .o_cfg_error(cerr));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Per channel {idx[3:0], ramp_en, ramp_down}; down only counts when enabled
  function automatic logic [11:0] mdl(input logic [1:0] l, r, input logic [2:0] c, input logic [3:0] p,
    input logic [2:0] s);
    logic [3:0] b;
    logic [5:0] a;
    logic [5:0] z;
    logic one;
    b = {p[0], p[1], p[2], p[3]};
    a = 6'h0;
    z = 6'h0;
    one = 1'b0;
    case ({r, l})
      4'h0: return {3'h0, p[2], 5'h0, p[3], 2'h0};
      4'h1: if (c == 3'h5) return {2'h0, b[3:2], 4'h0, b[1:0], 2'h0};
      4'h2, 4'h3: begin
        a = {l == 2'h3 ? b : {1'b0, b[3:1]}, 2'h0};
        one = c[1];
      end
      4'h4: if (c == 3'h5) return {3'h0, p[0], 1'b1, p[2], 3'h0, p[1], 1'b1, p[3]};
      4'hA: begin
        a = {1'b0, b[3:1], 1'b1, p[3]};
        one = c[1];
      end
      4'hC: begin
        z = {3'h0, s[0], s[0] & s[2], 1'b0};
        return {3'h0, p[2], z[2:1] & {2{~s[1]}}, 3'h0, p[3], z[2:1] & {2{s[1]}}};
      end
      4'hD: if (c == 3'h5) return {2'h0, b[3:2], 1'b1, s[0], 2'h0, b[1:0], 1'b1, s[1]};
      4'hF: begin
        a = {b, 1'b1, s[0]};
        one = c[1];
      end
      default: one = 1'b0;
    endcase
    if (!one) return 12'h0;
    return c[0] ? {6'h0, a} : {a, 6'h0};
  endfunction : mdl

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    rd <= ~w;
    wr <= w;
    ad <= a;
    wd <= d;
    do @(posedge i_clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h18, 32'hA5A5_5A5A);
    bus(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 160; i++) begin
      e = xs();
      {lv, rs, pc} = e[6:0];
      bus(1'b1, 8'h00, {17'h0, pc, rs, lv, 8'h0});
      e = xs();
      pp <= e[3:0];
      sp <= e[6:4];
      repeat (6) @(posedge i_clk);
      m = mdl(lv, rs, pc, e[3:0], e[6:4]);
      chk({c0.word_idx, c0.ramp_en, c0.ramp_down & c0.ramp_en}, m[11:6]);
      chk({c1.word_idx, c1.ramp_en, c1.ramp_down & c1.ramp_en}, m[5:0]);
      chk({sbit, cerr}, {rs == 2'h3, rs == 2'h3 && lv == 2'h2});
      bus(1'b0, 8'h14, 32'h0);
      chk({q[19:12], q[6:0]}, {m[5:2], m[11:8], e[6:0]});
    end
    pp <= 4'h0;
    sp <= 3'h0;
    bus(1'b1, 8'h00, 32'h0);
    e = xs();
    bus(1'b1, 8'h0C, e);
    bus(1'b0, 8'h0C, 32'h0);
    chk(q, e);
    be <= 4'h1;
    bus(1'b1, 8'h0C, 32'h0);
    be <= 4'hF;
    e[7:0] = 8'h00;
    bus(1'b0, 8'h0C, 32'h0);
    chk(q, e);
    for (int t = 1; t < 4; t++) begin
      bus(1'b1, 8'h04, (32'(t) << 22) | 32'h0000_4000);
      repeat (3) @(posedge i_clk);
      chk({c0.sweep_active, c0.start_reg}, {1'b1, t == 1 ? 8'h06 : t == 2 ? 8'h04 : 8'h05});
      chk(c0.end_word, t == 2 ? e : e >> (t == 1 ? 22 : 18));
      pp <= 4'h4;
      repeat (5) @(posedge i_clk);
      chk({c0.sweep_rise, c0.sweep_fall}, 2'h2);
      @(posedge i_clk);
      chk({c0.sweep_up, c1.sweep_up, c0.sweep_rise}, 3'h4);
      pp <= 4'h0;
      repeat (5) @(posedge i_clk);
      chk({c0.sweep_rise, c0.sweep_fall}, 2'h1);
      @(posedge i_clk);
      chk({c0.sweep_up, c0.sweep_fall}, 2'h0);
    end
    bus(1'b1, 8'h04, 32'h0000_4000);
    repeat (3) @(posedge i_clk);
    chk(c0.sweep_active, 1'b0);
    bus(1'b1, 8'h10, e);
    bus(1'b1, 8'h08, 32'h0080_4000);
    bus(1'b1, 8'h00, 32'h0000_0C00);
    pp <= 4'h8;
    sp <= 3'h5;
    repeat (6) @(posedge i_clk);
    chk({c1.sweep_up, c0.sweep_up, c1.word_idx}, 6'h20);
    chk({c0.ramp_en, c0.ramp_down, c1.ramp_en}, 3'h6);
    chk({c1.sweep_active, c1.start_reg, c1.end_reg}, {1'b1, 8'h04, 8'h0A});
    chk(c1.end_word, e);
    bus(1'b1, 8'h00, 32'h0000_0100);
    repeat (3) @(posedge i_clk);
    chk(cerr, 1'b1);
    conclude();
  end
endmodule : dpr_router_tb_top
